// ---- common/fspc_pkg.sv ----
package fspc_pkg;

  typedef enum logic [3:0] {
    OP_VERIFY,
    OP_PROTECT,
    OP_UNPROTECT_ALL,
    OP_SEC_ENTER,
    OP_SEC_EXIT,
    OP_SEC_LOCK,
    OP_READ_LOCKBIT,
    OP_HW_RESET
  } fspc_op_t;

  // Requested level of the hardware reset pin
  typedef enum logic [1:0] {
    RST_LOW,
    RST_HIGH,
    RST_IDENT
  } fspc_rst_t;

  // Requested level of guard_accel_pin
  typedef enum logic [1:0] {
    GUARD_LOW,
    GUARD_HIGH,
    GUARD_ACCEL
  } fspc_guard_t;

  typedef struct packed {
    fspc_op_t op;
    logic [7:0] sector;
    logic keep;
  } fspc_req_t;

  typedef struct packed {
    logic [21:0] addr;
    logic [7:0] dqOut;
    logic dqOe;
    logic ceN;
    logic oeN;
    logic weN;
  } fspc_pins_t;

endpackage : fspc_pkg

// ---- common/fspc_regs.svh ----
`ifndef FSPC_REGS_SVH
`define FSPC_REGS_SVH

// ==========================================================
// Clock and timing
`define FSPC_CLK_MHZ 200
`define FSPC_BUS_CYCLE_NS 70
`define FSPC_HV_SETTLE_NS 4000
`define FSPC_RESET_LOW_NS 500
`define FSPC_PULSE_US 150
`define FSPC_MAX_TRIES 25

// ==========================================================
// Sector geometry
`define FSPC_LAST_SECTOR 141
`define FSPC_SMALL_LOW_LAST 7
`define FSPC_SMALL_HIGH_FIRST 134
`define FSPC_SMALL_HIGH_BASE 10'h3f8
`define FSPC_SECTOR_LSB 12

// ==========================================================
// Low address bits, write data and read-back bit positions of protection cycles
`define FSPC_VERIFY_LOW 12'h002
`define FSPC_PROTECT_LOW 12'h002
`define FSPC_UNPROTECT_LOW 12'h042
`define FSPC_LOCKBIT_LOW 12'h003
`define FSPC_PROT_DATA 8'h60
`define FSPC_PROT_BIT 0
`define FSPC_LOCK_BIT 7

// ==========================================================
// Secured sector command words
`define FSPC_UNLOCK_ADDR1 22'h000555
`define FSPC_UNLOCK_ADDR2 22'h0002aa
`define FSPC_UNLOCK_DATA1 8'haa
`define FSPC_UNLOCK_DATA2 8'h55
`define FSPC_ENTER_DATA 8'h88
`define FSPC_EXIT_DATA 8'h90
`define FSPC_EXIT_FINAL 8'h00
`define FSPC_ENTER_LEN 3
`define FSPC_EXIT_LEN 4

`endif

// ---- core/fspc_bus_cycle.sv ----
`timescale 1ns/1ps
`include "fspc_regs.svh"

module fspc_bus_cycle
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic isWrite,
  input wire logic [21:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] dqIn,
  output fspc_pkg::fspc_pins_t pins,
  output logic busy,
  output logic done,
  output logic [7:0] rdata
);
  import fspc_pkg::*;

  localparam int unsigned CycleClks =
    (`FSPC_BUS_CYCLE_NS * `FSPC_CLK_MHZ + 999) / 1000;

  fspc_pins_t pins_r, pins_nxt;
  logic [7:0] dqMeta_r, dqSync_r, rdata_r, rdata_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic busy_r, busy_nxt, done_r, done_nxt;

  // ==========================================================
  // Strobe timing
  always_comb
  begin
    pins_nxt = pins_r;
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    rdata_nxt = rdata_r;
    if (!busy_r && start)
    begin
      busy_nxt = 1'b1;
      cnt_nxt = 8'(CycleClks + 2);
      pins_nxt.addr = addr;
      pins_nxt.dqOut = wdata;
      pins_nxt.dqOe = isWrite;
      pins_nxt.ceN = 1'b0;
      pins_nxt.oeN = isWrite;
      pins_nxt.weN = !isWrite;
    end
    else if (busy_r)
    begin
      if (cnt_r == 8'h00)
      begin
        // Two extra counts cover the data synchroniser delay
        rdata_nxt = dqSync_r;
        pins_nxt.ceN = 1'b1;
        pins_nxt.oeN = 1'b1;
        pins_nxt.weN = 1'b1;
        pins_nxt.dqOe = 1'b0;
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end
      else
      begin
        cnt_nxt = cnt_r - 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      pins_r <= '{addr: 22'h000000, dqOut: 8'h00, dqOe: 1'b0,
                 ceN: 1'b1, oeN: 1'b1, weN: 1'b1};
      cnt_r <= 8'h00;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      rdata_r <= 8'h00;
      dqMeta_r <= 8'h00;
      dqSync_r <= 8'h00;
    end
    else
    begin
      pins_r <= pins_nxt;
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      rdata_r <= rdata_nxt;
      dqMeta_r <= dqIn;
      dqSync_r <= dqMeta_r;
    end
  end

  assign pins = pins_r;
  assign busy = busy_r;
  assign done = done_r;
  assign rdata = rdata_r;

endmodule : fspc_bus_cycle

// ---- core/fspc_host.sv ----
`timescale 1ns/1ps
`include "fspc_regs.svh"

// What this block does
// - Ident high voltage on reset pin, and on A9 (a9IdentHv) during verify reads
// - Protect unprotected sectors before unprotect pulse
// - Re-protect formerly protected sectors one by one
// - Guard pin always driven to defined level
// - Lock secured sector: enter, then protect
module fspc_host
#(
  parameter int unsigned PULSE_CLKS = `FSPC_PULSE_US * `FSPC_CLK_MHZ
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic reqValid,
  output logic reqReady,
  input fspc_pkg::fspc_req_t req,
  input wire logic tempUnprotect,
  input fspc_pkg::fspc_guard_t guardReq,
  output logic respValid,
  output logic respOk,
  output logic respProt,
  output logic respLock,
  output logic secMode,
  input wire logic [7:0] dqIn,
  output logic [7:0] dqOut,
  output logic dqOe,
  output logic [21:0] flashAddr,
  output logic ceN,
  output logic oeN,
  output logic weN,
  output fspc_pkg::fspc_rst_t resetLevel,
  output logic a9IdentHv,
  output fspc_pkg::fspc_guard_t guardLevel
);
  import fspc_pkg::*;

  localparam int unsigned SettleClks = (`FSPC_HV_SETTLE_NS * `FSPC_CLK_MHZ + 999) / 1000;
  localparam int unsigned RstClks = (`FSPC_RESET_LOW_NS * `FSPC_CLK_MHZ + 999) / 1000;

  typedef enum logic [3:0] {
    S_IDLE, S_HVUP, S_PULSE, S_HOLD, S_VER, S_SCAN, S_HVDN, S_CMD, S_RST, S_DONE
  } fspc_state_t;
  typedef enum logic [1:0] {PH_PREP, PH_UNPROT, PH_REPROT} fspc_phase_t;

  // ==========================================================
  // Helpers
  function automatic logic [21:0] sectorAddr(input logic [7:0] s, input logic [11:0] low);
    logic [9:0] code;
    if (s <= 8'(`FSPC_SMALL_LOW_LAST))
      code = {2'b00, s};
    else if (s >= 8'(`FSPC_SMALL_HIGH_FIRST))
      code = `FSPC_SMALL_HIGH_BASE + {2'b00, s - 8'(`FSPC_SMALL_HIGH_FIRST)};
    else
      code = {s - 8'(`FSPC_SMALL_LOW_LAST), 2'b00} << 1;
    return {code, low};
  endfunction : sectorAddr

  function automatic logic [29:0] cmdWord(input logic isExit, input logic [1:0] idx);
    logic [29:0] w;
    unique case (idx)
      2'd0: w = {`FSPC_UNLOCK_ADDR1, `FSPC_UNLOCK_DATA1};
      2'd1: w = {`FSPC_UNLOCK_ADDR2, `FSPC_UNLOCK_DATA2};
      2'd2: w = {`FSPC_UNLOCK_ADDR1, isExit ? `FSPC_EXIT_DATA : `FSPC_ENTER_DATA};
      default: w = {22'h000000, `FSPC_EXIT_FINAL};
    endcase
    return w;
  endfunction : cmdWord

  fspc_state_t state_r, state_nxt;
  fspc_phase_t phase_r, phase_nxt;
  fspc_req_t cur_r, cur_nxt;
  fspc_rst_t rst_r, rst_nxt;
  fspc_guard_t guard_r, guard_nxt;
  logic [7:0] sec_r, sec_nxt, tries_r, tries_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [1:0] seqIdx_r, seqIdx_nxt;
  logic unprot_r, unprot_nxt, exiting_r, exiting_nxt, issued_r, issued_nxt;
  logic secMode_r, secMode_nxt, a9_r, a9_nxt;
  logic ok_r, ok_nxt, prot_r, prot_nxt, lock_r, lock_nxt, resp_r, resp_nxt;
  logic wasProt_r [0:`FSPC_LAST_SECTOR];
  logic wasSet, busStart, busWrite, busDone, busBusy, isProt, lastSec;
  logic [21:0] busAddr;
  logic [7:0] busData, busRd;
  fspc_pins_t pins;

  assign isProt = busRd[`FSPC_PROT_BIT];
  assign lastSec = (sec_r == 8'(`FSPC_LAST_SECTOR));

  // ==========================================================
  // Sequencer
  always_comb
  begin
    state_nxt = state_r;
    phase_nxt = phase_r;
    cur_nxt = cur_r;
    rst_nxt = rst_r;
    sec_nxt = sec_r;
    tries_nxt = tries_r;
    cnt_nxt = cnt_r;
    seqIdx_nxt = seqIdx_r;
    unprot_nxt = unprot_r;
    exiting_nxt = exiting_r;
    issued_nxt = issued_r;
    secMode_nxt = secMode_r;
    a9_nxt = a9_r;
    ok_nxt = ok_r;
    prot_nxt = prot_r;
    lock_nxt = lock_r;
    resp_nxt = 1'b0;
    wasSet = 1'b0;
    busStart = 1'b0;
    busWrite = 1'b0;
    busAddr = sectorAddr(sec_r, `FSPC_VERIFY_LOW);
    busData = 8'h00;
    // Accel is withheld while the overlay is mapped in
    guard_nxt = (guardReq == GUARD_ACCEL && secMode_r) ? GUARD_HIGH : guardReq;
    if (!(guardReq inside {GUARD_LOW, GUARD_HIGH, GUARD_ACCEL}))
      guard_nxt = GUARD_LOW;
    unique case (state_r)
      S_IDLE:
      begin
        // High voltage on reset pin held only while requested
        rst_nxt = tempUnprotect ? RST_IDENT : RST_HIGH;
        ok_nxt = 1'b1;
        tries_nxt = 8'h00;
        issued_nxt = 1'b0;
        seqIdx_nxt = 2'd0;
        unprot_nxt = 1'b0;
        if (reqValid)
        begin
          cur_nxt = req;
          sec_nxt = req.sector;
          unique case (req.op)
            OP_VERIFY, OP_READ_LOCKBIT: state_nxt = S_VER;
            OP_PROTECT:
            begin
              state_nxt = S_HVUP;
              cnt_nxt = 16'(SettleClks);
            end
            OP_UNPROTECT_ALL:
            begin
              phase_nxt = PH_PREP;
              sec_nxt = 8'h00;
              state_nxt = S_HVUP;
              cnt_nxt = 16'(SettleClks);
            end
            OP_SEC_ENTER, OP_SEC_LOCK:
            begin
              exiting_nxt = 1'b0;
              sec_nxt = 8'h00;
              state_nxt = S_CMD;
            end
            OP_SEC_EXIT:
            begin
              exiting_nxt = 1'b1;
              state_nxt = S_CMD;
            end
            OP_HW_RESET:
            begin
              rst_nxt = RST_LOW;
              cnt_nxt = 16'(RstClks);
              state_nxt = S_RST;
            end
            default: state_nxt = S_DONE;
          endcase
        end
      end
      S_HVUP:
      begin
        rst_nxt = RST_IDENT;
        if (cnt_r == 16'h0000)
          state_nxt = S_VER;
        else
          cnt_nxt = cnt_r - 16'h0001;
      end
      S_PULSE:
      begin
        busStart = !issued_r;
        busWrite = 1'b1;
        busData = `FSPC_PROT_DATA;
        // One unprotect pulse targets the whole array at once
        busAddr = unprot_r ? sectorAddr(8'h00, `FSPC_UNPROTECT_LOW)
                           : sectorAddr(sec_r, `FSPC_PROTECT_LOW);
        if (!busBusy && !issued_r)
          issued_nxt = 1'b1;
        if (busDone)
        begin
          issued_nxt = 1'b0;
          cnt_nxt = 16'(PULSE_CLKS);
          state_nxt = S_HOLD;
        end
      end
      S_HOLD:
      begin
        if (cnt_r == 16'h0000)
        begin
          tries_nxt = tries_r + 8'h01;
          state_nxt = S_VER;
        end
        else
          cnt_nxt = cnt_r - 16'h0001;
      end
      S_VER:
      begin
        a9_nxt = 1'b1;
        busStart = !issued_r;
        busAddr = (cur_r.op == OP_READ_LOCKBIT) ? {10'h000, `FSPC_LOCKBIT_LOW}
                                                : sectorAddr(sec_r, `FSPC_VERIFY_LOW);
        if (!busBusy && !issued_r)
          issued_nxt = 1'b1;
        if (busDone)
        begin
          issued_nxt = 1'b0;
          a9_nxt = 1'b0;
          prot_nxt = isProt;
          lock_nxt = busRd[`FSPC_LOCK_BIT];
          state_nxt = S_PULSE;
          unique case (cur_r.op)
            OP_VERIFY, OP_READ_LOCKBIT: state_nxt = S_DONE;
            OP_UNPROTECT_ALL:
            begin
              unique case (phase_r)
                PH_PREP:
                begin
                  wasSet = (tries_r == 8'h00);
                  if (isProt)
                  begin
                    tries_nxt = 8'h00;
                    sec_nxt = sec_r + 8'h01;
                    state_nxt = S_VER;
                    if (lastSec)
                    begin
                      // Everything protected; now one pulse clears all
                      phase_nxt = PH_UNPROT;
                      sec_nxt = 8'h00;
                      unprot_nxt = 1'b1;
                      state_nxt = S_PULSE;
                    end
                  end
                end
                PH_UNPROT:
                begin
                  if (isProt)
                    sec_nxt = 8'h00;
                  else if (lastSec)
                  begin
                    phase_nxt = PH_REPROT;
                    unprot_nxt = 1'b0;
                    sec_nxt = 8'h00;
                    state_nxt = S_SCAN;
                  end
                  else
                  begin
                    sec_nxt = sec_r + 8'h01;
                    state_nxt = S_VER;
                  end
                end
                default:
                begin
                  if (isProt)
                  begin
                    sec_nxt = sec_r + 8'h01;
                    state_nxt = S_SCAN;
                  end
                end
              endcase
            end
            default:
            begin
              if (isProt)
                state_nxt = (cur_r.op == OP_SEC_LOCK) ? S_CMD : S_HVDN;
            end
          endcase
          // Give up on a sector that will not change
          if (state_nxt == S_PULSE && tries_r == 8'(`FSPC_MAX_TRIES))
          begin
            ok_nxt = 1'b0;
            state_nxt = (cur_r.op == OP_SEC_LOCK) ? S_CMD : S_HVDN;
          end
          if (state_nxt == S_CMD)
            exiting_nxt = 1'b1;
          if (state_nxt == S_HVDN)
            cnt_nxt = 16'(SettleClks);
        end
      end
      S_SCAN:
      begin
        tries_nxt = 8'h00;
        if (sec_r > 8'(`FSPC_LAST_SECTOR))
        begin
          cnt_nxt = 16'(SettleClks);
          state_nxt = S_HVDN;
        end
        else if (cur_r.keep && wasProt_r[sec_r])
          state_nxt = S_PULSE;
        else
          sec_nxt = sec_r + 8'h01;
      end
      S_HVDN:
      begin
        rst_nxt = RST_HIGH;
        if (cnt_r == 16'h0000)
          state_nxt = S_DONE;
        else
          cnt_nxt = cnt_r - 16'h0001;
      end
      S_CMD:
      begin
        busStart = !issued_r;
        busWrite = 1'b1;
        {busAddr, busData} = cmdWord(exiting_r, seqIdx_r);
        if (!busBusy && !issued_r)
          issued_nxt = 1'b1;
        if (busDone)
        begin
          issued_nxt = 1'b0;
          seqIdx_nxt = seqIdx_r + 2'd1;
          if (seqIdx_r == 2'(exiting_r ? `FSPC_EXIT_LEN - 1 : `FSPC_ENTER_LEN - 1))
          begin
            seqIdx_nxt = 2'd0;
            secMode_nxt = !exiting_r;
            state_nxt = (cur_r.op == OP_SEC_LOCK && !exiting_r) ? S_VER : S_DONE;
          end
        end
      end
      S_RST:
      begin
        if (cnt_r == 16'h0000)
        begin
          rst_nxt = RST_HIGH;
          secMode_nxt = 1'b0;
          state_nxt = S_DONE;
        end
        else
          cnt_nxt = cnt_r - 16'h0001;
      end
      default:
      begin
        resp_nxt = 1'b1;
        state_nxt = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_r <= S_IDLE;
      phase_r <= PH_PREP;
      cur_r <= '{op: OP_VERIFY, sector: 8'h00, keep: 1'b0};
      rst_r <= RST_HIGH;
      guard_r <= GUARD_LOW;
      sec_r <= 8'h00;
      tries_r <= 8'h00;
      cnt_r <= 16'h0000;
      seqIdx_r <= 2'd0;
      unprot_r <= 1'b0;
      exiting_r <= 1'b0;
      issued_r <= 1'b0;
      secMode_r <= 1'b0;
      a9_r <= 1'b0;
      ok_r <= 1'b0;
      prot_r <= 1'b0;
      lock_r <= 1'b0;
      resp_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
      cur_r <= cur_nxt;
      rst_r <= rst_nxt;
      guard_r <= guard_nxt;
      sec_r <= sec_nxt;
      tries_r <= tries_nxt;
      cnt_r <= cnt_nxt;
      seqIdx_r <= seqIdx_nxt;
      unprot_r <= unprot_nxt;
      exiting_r <= exiting_nxt;
      issued_r <= issued_nxt;
      secMode_r <= secMode_nxt;
      a9_r <= a9_nxt;
      ok_r <= ok_nxt;
      prot_r <= prot_nxt;
      lock_r <= lock_nxt;
      resp_r <= resp_nxt;
    end
  end

  // Memory of which sectors were protected at their first verify, before any prepare pulse
  always_ff @(posedge core_clk)
  begin
    if (wasSet && sec_r <= 8'(`FSPC_LAST_SECTOR))
      wasProt_r[sec_r] <= isProt;
  end

  fspc_bus_cycle u_bus
  (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .start(busStart),
    .isWrite(busWrite),
    .addr(busAddr),
    .wdata(busData),
    .dqIn(dqIn),
    .pins(pins),
    .busy(busBusy),
    .done(busDone),
    .rdata(busRd)
  );

  assign reqReady = (state_r == S_IDLE);
  assign respValid = resp_r;
  assign respOk = ok_r;
  assign respProt = prot_r;
  assign respLock = lock_r;
  assign secMode = secMode_r;
  assign dqOut = pins.dqOut;
  assign dqOe = pins.dqOe;
  assign flashAddr = pins.addr;
  assign ceN = pins.ceN;
  assign oeN = pins.oeN;
  assign weN = pins.weN;
  assign resetLevel = rst_r;
  assign a9IdentHv = a9_r;
  assign guardLevel = guard_r;

endmodule : fspc_host

// ---- verif/fspc_flash_model.sv ----
`timescale 1ns/1ps
// ==========================================
// Far-side flash: protection bits, overlay, lock indicator
module fspc_flash_model
#(
  parameter bit FACTORY_LOCKED = 1'b0
)
(
  input wire logic ceN,
  input wire logic oeN,
  input wire logic weN,
  input wire logic [21:0] flashAddr,
  input wire logic [7:0] dqOut,
  input wire logic dqOe,
  input fspc_pkg::fspc_rst_t resetLevel,
  input wire logic a9IdentHv,
  output logic [7:0] dqIn,
  output int orderErr,
  output logic overlay,
  output logic secLock
);
  import fspc_pkg::*;
  logic prot [0:141];
  logic [7:0] rdVal;
  logic [7:0] lastDq = 8'h00;
  logic wr;
  function automatic int secOf(input logic [9:0] c);
    if (c < 10'h008)
      return int'(c);
    if (c >= 10'h3f8)
      return int'(c) - 1016 + 134;
    return int'(c) / 8 + 7;
  endfunction : secOf
  // Bits are nonvolatile: nothing but the pulses below changes them
  initial
  begin
    foreach (prot[i])
      prot[i] = 1'b0;
    orderErr = 0;
    overlay = 1'b0;
    secLock = FACTORY_LOCKED;
  end
  always_comb
    if (flashAddr[11:0] == 12'h003)
      rdVal = {FACTORY_LOCKED, 7'h01};
    else if (a9IdentHv && overlay)
      rdVal = {7'h00, secLock};
    else if (a9IdentHv)
      rdVal = {7'h00, prot[secOf(flashAddr[21:12])]};
    else
      rdVal = 8'hff;
  // Released bus shows the inverse of the last value, never a held copy
  assign dqIn = (!ceN && !oeN) ? rdVal : ~lastDq;
  assign wr = !ceN && dqOe;
  always @(posedge oeN)
    lastDq = rdVal;
  always @(negedge weN)
  begin
    #1;
    if (wr && dqOut == 8'h88)
      overlay = 1'b1;
    else if (wr && dqOut == 8'h00 && flashAddr == 22'h000000)
      overlay = 1'b0;
    else if (wr && dqOut == 8'h60 && flashAddr[11:0] == 12'h002 && overlay)
      secLock = 1'b1;
    else if (wr && dqOut == 8'h60 && flashAddr[11:0] == 12'h002 && resetLevel == RST_IDENT)
      prot[secOf(flashAddr[21:12])] = 1'b1;
    else if (wr && dqOut == 8'h60 && flashAddr[11:0] == 12'h042 && resetLevel == RST_IDENT)
    begin
      if (!prot.and())
        orderErr++;
      foreach (prot[i])
        prot[i] = 1'b0;
    end
  end
  always @(resetLevel)
    if (resetLevel == RST_LOW)
      overlay = 1'b0;
endmodule : fspc_flash_model

// ---- verif/fspc_host_props.sv ----
`timescale 1ns/1ps
// ==========================================
// Port checks on the protection sequencer
module fspc_host_props
#(
  parameter int unsigned PULSE_CLKS = 30000
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic reqReady,
  input wire logic tempUnprotect,
  input fspc_pkg::fspc_guard_t guardReq,
  input wire logic respValid,
  input wire logic secMode,
  input wire logic dqOe,
  input wire logic ceN,
  input wire logic oeN,
  input wire logic weN,
  input fspc_pkg::fspc_rst_t resetLevel,
  input wire logic a9IdentHv,
  input fspc_pkg::fspc_guard_t guardLevel
);
  import fspc_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  chk_reset_quiet: assert property ($fell(sys_rst) |-> reqReady && ceN && oeN && weN
    && !dqOe && !secMode && resetLevel == RST_HIGH && guardLevel == GUARD_LOW)
    else $error("outputs not idle after reset");
  chk_guard_high: assert property (!$past(sys_rst) && $past(guardReq) == GUARD_HIGH
    |-> guardLevel == GUARD_HIGH) else $error("guard high not passed on");
  chk_guard_low: assert property (!$past(sys_rst) && $past(guardReq) == GUARD_LOW
    |-> guardLevel == GUARD_LOW) else $error("guard low not passed on");
  chk_accel_demoted: assert property ($past(secMode) && secMode && !$past(sys_rst)
    && $past(guardReq) == GUARD_ACCEL |-> guardLevel == GUARD_HIGH)
    else $error("accel level while overlay mapped");
  chk_resp_pulse: assert property (respValid |-> reqReady ##1 !respValid)
    else $error("response not a single pulse");
  chk_write_strobe: assert property ($fell(weN) |-> (!ceN && oeN && dqOe) ##1 (!weN) [*8])
    else $error("write strobe malformed");
  chk_a9_read_only: assert property (a9IdentHv |-> weN && !dqOe)
    else $error("high voltage during write");
  chk_temp_ident: assert property ((reqReady && tempUnprotect) [*3]
    |-> resetLevel == RST_IDENT) else $error("temporary unprotect level missing");
  chk_accel_passed: assert property (!$past(sys_rst) && !$past(secMode)
    && $past(guardReq) == GUARD_ACCEL |-> guardLevel == GUARD_ACCEL)
    else $error("accel level not passed on");
  chk_guard_defined: assert property (
    guardLevel inside {GUARD_LOW, GUARD_HIGH, GUARD_ACCEL}) else $error("guard level undefined");
endmodule : fspc_host_props
bind fspc_host fspc_host_props #(.PULSE_CLKS(PULSE_CLKS)) fspc_host_props_inst (
  .core_clk(core_clk), .sys_rst(sys_rst), .reqReady(reqReady), .tempUnprotect(tempUnprotect),
  .guardReq(guardReq), .respValid(respValid), .secMode(secMode), .dqOe(dqOe), .ceN(ceN),
  .oeN(oeN), .weN(weN), .resetLevel(resetLevel), .a9IdentHv(a9IdentHv),
  .guardLevel(guardLevel));

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
// ==========================================
// Self-checking bench: sequencer against a flash model
module testbench;
  import fspc_pkg::*;
  localparam int SECTORS = 142;
  localparam int LIMIT = 60000;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reqValid = 1'b0;
  fspc_req_t req = '0;
  logic tempUnprotect = 1'b0;
  fspc_guard_t guardReq = GUARD_HIGH;
  logic gRand = 1'b1;
  logic reqReady, respValid, respOk, respProt, respLock, secMode;
  logic dqOe, ceN, oeN, weN, a9IdentHv, overlay, secLock;
  logic [7:0] dqIn, dqOut;
  logic [21:0] flashAddr;
  fspc_rst_t resetLevel;
  fspc_guard_t guardLevel;
  int orderErr;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  int seed = 17;
  int r;
  int expProt [SECTORS];
  int edges [8] = '{0, 1, 140, 141, 7, 8, 133, 134};
  // Short pulse keeps the protect loops inside the run budget
  fspc_host #(.PULSE_CLKS(20)) fspc_host_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .reqValid(reqValid), .reqReady(reqReady),
    .req(req), .tempUnprotect(tempUnprotect), .guardReq(guardReq), .respValid(respValid),
    .respOk(respOk), .respProt(respProt), .respLock(respLock), .secMode(secMode),
    .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .flashAddr(flashAddr), .ceN(ceN), .oeN(oeN),
    .weN(weN), .resetLevel(resetLevel), .a9IdentHv(a9IdentHv), .guardLevel(guardLevel));
  fspc_flash_model #(.FACTORY_LOCKED(1'b0)) fspc_flash_model_inst (
    .ceN(ceN), .oeN(oeN), .weN(weN), .flashAddr(flashAddr), .dqOut(dqOut), .dqOe(dqOe),
    .resetLevel(resetLevel), .a9IdentHv(a9IdentHv), .dqIn(dqIn), .orderErr(orderErr),
    .overlay(overlay), .secLock(secLock));
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      failures++;
      summarize();
    end
  end
  // Guard level wanders, undefined code included; parked on accel when held
  always @(negedge core_clk)
    guardReq <= gRand ? fspc_guard_t'(2'($unsigned($random(seed)) % 4)) : GUARD_ACCEL;
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("FAIL %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  task automatic summarize();
    if (failures == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic do_op(input fspc_op_t code, input int sec, input logic keep);
    int n;
    @(negedge core_clk);
    req = '{op: code, sector: 8'(sec), keep: keep};
    reqValid = 1'b1;
    for (n = 0; n < 100 && reqReady !== 1'b1; n++)
      @(negedge core_clk);
    @(negedge core_clk);
    reqValid = 1'b0;
    for (n = 0; n < 70000 && respValid !== 1'b1; n++)
    begin
      @(posedge core_clk);
      #1;
    end
    check("respValid", respValid, 1'b1);
    check("respOk", respOk, 1'b1);
  endtask : do_op
  task automatic verify(input int sec);
    do_op(OP_VERIFY, sec, 1'b0);
    check("respProt", respProt, expProt[sec][0]);
  endtask : verify
  initial
  begin
    foreach (expProt[i])
      expProt[i] = 0;
    repeat (3) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (4) verify(int'($unsigned($random(seed)) % SECTORS));
    do_op(OP_READ_LOCKBIT, 0, 1'b0);
    check("respLock", respLock, 1'b0);
    foreach (edges[i])
    begin
      do_op(OP_PROTECT, edges[i], 1'b0);
      expProt[edges[i]] = 1;
      verify(edges[i]);
    end
    r = 9 + int'($unsigned($random(seed)) % 120);
    do_op(OP_PROTECT, r, 1'b0);
    expProt[r] = 1;
    @(negedge core_clk);
    tempUnprotect = 1'b1;
    repeat (4) @(negedge core_clk);
    check("resetLevel", resetLevel, RST_IDENT);
    tempUnprotect = 1'b0;
    repeat (4) @(negedge core_clk);
    check("resetLevel", resetLevel, RST_HIGH);
    do_op(OP_UNPROTECT_ALL, 0, 1'b1);
    check("orderErr", orderErr, 0);
    for (int i = 0; i < SECTORS; i++)
      verify(i);
    do_op(OP_SEC_LOCK, 0, 1'b0);
    check("secLock", {secMode, secLock}, 2'b01);
    do_op(OP_SEC_ENTER, 0, 1'b0);
    check("overlay", {secMode, overlay}, 2'b11);
    gRand = 1'b0;
    repeat (3) @(negedge core_clk);
    check("guardLevel", guardLevel, GUARD_HIGH);
    gRand = 1'b1;
    do_op(OP_SEC_EXIT, 0, 1'b0);
    check("overlay", {secMode, overlay}, 2'b00);
    do_op(OP_SEC_ENTER, 0, 1'b0);
    do_op(OP_HW_RESET, 0, 1'b0);
    check("overlay", {secMode, overlay}, 2'b00);
    verify(edges[3]);
    summarize();
  end
endmodule : testbench
